// >>> core/acsic_pkg.sv
// constants, carriers and state type for the accelerometer state and interrupt control block
// assumes a single 10 MHz clock domain shared with the serial protocol engine
`default_nettype none
package acsic_pkg;
   // register offsets (byte addresses on the serial register port)
   localparam logic [7:0] ACSIC_MOTION_FLAGS_OFF = 8'h03;
   localparam logic [7:0] ACSIC_ISTAT_ALIAS_OFF = 8'h04;
   localparam logic [7:0] ACSIC_DEV_STATUS_OFF = 8'h05;
   localparam logic [7:0] ACSIC_INT_EN_OFF = 8'h06;
   localparam logic [7:0] ACSIC_POWER_MODE_OFF = 8'h07;
   localparam logic [7:0] ACSIC_WORK_MODE_OFF = 8'h08;
   localparam logic [7:0] ACSIC_FEATURE_OFF = 8'h09;
   localparam logic [7:0] ACSIC_QUEUE_FLAGS_OFF = 8'h0A;
   localparam logic [7:0] ACSIC_X_LO_OFF = 8'h0D;
   localparam logic [7:0] ACSIC_MOTION_ALT_OFF = 8'h13;
   localparam logic [7:0] ACSIC_ISTAT_OFF = 8'h14;
   localparam logic [7:0] ACSIC_RANGE_OFF = 8'h20;
   localparam logic [7:0] ACSIC_QUEUE_CTL_OFF = 8'h2D;
   localparam logic [7:0] ACSIC_QUEUE_THR_OFF = 8'h2E;
   localparam logic [7:0] ACSIC_QUEUE_ISTAT_OFF = 8'h2F;
   localparam logic [7:0] ACSIC_ROUTE_OFF = 8'h31;
   localparam logic [7:0] ACSIC_PIN_CTL_OFF = 8'h33;
   // field positions
   localparam int ACSIC_TILT_BIT = 0;
   localparam int ACSIC_FLIP_BIT = 1;
   localparam int ACSIC_MOVE_BIT = 2;
   localparam int ACSIC_SHAKE_BIT = 3;
   localparam int ACSIC_DTAP_BIT = 4;
   localparam int ACSIC_QUEUE_SUM_BIT = 5;
   localparam int ACSIC_ACQ_BIT = 7;
   localparam int ACSIC_FEAT_TF_BIT = 0;
   localparam int ACSIC_FEAT_MOVE_BIT = 2;
   localparam int ACSIC_FEAT_SHAKE_BIT = 3;
   localparam int ACSIC_QFULL_BIT = 1;
   localparam int ACSIC_QLEVEL_BIT = 2;
   localparam int ACSIC_QCOMB_BIT = 3;
   localparam int ACSIC_QEN_BIT = 5;
   localparam int ACSIC_SWAP_BIT = 4;
   localparam int ACSIC_PERBIT_BIT = 6;
   localparam int ACSIC_SWRST_BIT = 6;
   localparam int ACSIC_P1_POL_BIT = 2;
   localparam int ACSIC_P1_DRV_BIT = 3;
   localparam int ACSIC_P2_POL_BIT = 6;
   localparam int ACSIC_P2_DRV_BIT = 7;
   // encodings and reset values
   localparam logic [1:0] ACSIC_PM_STANDBY = 2'h0;
   localparam logic [1:0] ACSIC_PM_WAKE = 2'h1;
   localparam logic [7:0] ACSIC_WORK_RST = 8'h13;
   localparam logic [7:0] ACSIC_QTHR_RST = 8'h10;
   localparam logic [7:0] ACSIC_PIN_CTL_RST = 8'h00;
   localparam logic [2:0] ACSIC_RANGE_RST = 3'h0;
   localparam logic signed [15:0] ACSIC_FS_POS = 16'sh7FFF;
   localparam logic signed [15:0] ACSIC_FS_NEG = 16'sh8000;
   localparam int ACSIC_SENS_12G = 2730;
   localparam int ACSIC_SENS_SHIFT = 14;
   // wake latency bound
   localparam int ACSIC_WAKE_NS = 10000;
   localparam int ACSIC_CLK_NS = 100;
   localparam int ACSIC_WAKE_CYC = ACSIC_WAKE_NS / ACSIC_CLK_NS;

   typedef enum logic {ACSIC_STBY, ACSIC_WAKE} acsic_state_e;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } acsic_axes_s;

   typedef struct packed {
      logic tilt;
      logic flip;
      logic move;
      logic shake;
      logic dtap;
      logic stap;
   } acsic_events_s;
endpackage : acsic_pkg
`default_nettype wire

// >>> core/acsic_core.sv
// state control, sample encoding, interrupt status and pin routing of the accelerometer
// assumes the serial engine, motion engine and queue share clk; no input here needs syncing
`default_nettype none
module acsic_core
   import acsic_pkg::*;
#(
   parameter int CLK_HZ = 10_000_000,
   parameter int RAW_W = 20,
   parameter int QUEUE_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic bus_stop,
   input wire logic signed [RAW_W-1:0] raw_x,
   input wire logic signed [RAW_W-1:0] raw_y,
   input wire logic signed [RAW_W-1:0] raw_z,
   input wire acsic_events_s motion_event,
   input wire logic [3:0] motion_live,
   input wire logic [7:0] queue_count,
   output acsic_axes_s axis_result,
   output logic sample_tick,
   output logic engine_enable,
   output logic [2:0] range_code,
   output logic [7:0] work_mode_code,
   output logic queue_enable,
   output logic first_irq_pin_o,
   output logic first_irq_pin_oe_n,
   output logic second_irq_pin_o,
   output logic second_irq_pin_oe_n
);
   // the period counter, the saturating encoder and the 8-bit count cannot serve other values
   if (CLK_HZ < 2000 || RAW_W < 17 || RAW_W > 24 || QUEUE_DEPTH < 1 || QUEUE_DEPTH > 255) begin : g_bad_params
      $error("acsic_core: unsupported parameter values");
   end

   localparam int PW = RAW_W + 13;

   // sample period in clocks for a working-mode code; unknown codes fall back to 100 Hz
   function automatic logic [31:0] rate_period(input logic [7:0] code);
      int hz;
      case (code)
         8'h19, 8'h73: hz = 25;
         8'h1B, 8'h74: hz = 50;
         8'h3C, 8'h55, 8'h6D: hz = 125;
         8'h34, 8'h0C, 8'h86: hz = 250;
         8'h35, 8'h0D, 8'h6F: hz = 500;
         8'h2D, 8'h1E, 8'h67: hz = 1000;
         8'h06, 8'h47: hz = 2000;
         default: hz = 100;
      endcase
      return 32'(CLK_HZ / hz);
   endfunction : rate_period

   // scale a 2 g referenced raw value to the selected range and saturate
   function automatic logic signed [15:0] encode(input logic signed [RAW_W-1:0] v,
                                                 input logic [2:0] r);
      logic signed [PW-1:0] e;
      logic signed [PW-1:0] t;
      e = PW'(v);
      case (r)
         3'h1: t = e >>> 1;
         3'h2: t = e >>> 2;
         3'h3: t = (e * PW'(ACSIC_SENS_12G)) >>> ACSIC_SENS_SHIFT;
         3'h4: t = e >>> 3;
         default: t = e;
      endcase
      if (t > PW'(ACSIC_FS_POS)) begin
         return ACSIC_FS_POS;
      end else if (t < PW'(ACSIC_FS_NEG)) begin
         return ACSIC_FS_NEG;
      end else begin
         return t[15:0];
      end
   endfunction : encode

   acsic_state_e state_r, state_nxt;
   logic [7:0] int_en_r, int_en_nxt;
   logic [7:0] work_r, work_nxt;
   logic [7:0] feat_r, feat_nxt;
   logic [7:0] qctl_r, qctl_nxt;
   logic [7:0] qthr_r, qthr_nxt;
   logic [7:0] route_r, route_nxt;
   logic [7:0] pinctl_r, pinctl_nxt;
   logic [2:0] range_r, range_nxt;
   logic [7:0] istat_r, istat_nxt;
   logic [2:0] qstat_r, qstat_nxt;
   logic qfull_d_r, qfull_d_nxt;
   logic qlvl_d_r, qlvl_d_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic stop_r, stop_nxt;
   logic tick_r, tick_nxt;
   acsic_axes_s axes_r, axes_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [3:0] pin_r, pin_nxt;

   logic wake;
   logic wr_ok;
   logic tick;
   logic soft_rst;
   logic perbit;
   logic qen;
   logic qfull_lvl;
   logic qlvl_lvl;
   logic [7:0] ev_set;
   logic [7:0] clr;
   logic [2:0] qclr;
   logic req1;
   logic req2;
   logic line_a;
   logic line_b;
   logic [7:0] rd_val;
   logic [7:0] istat_view;

   always_comb begin
      wake = (state_r == ACSIC_WAKE);
      perbit = route_r[ACSIC_PERBIT_BIT];
      qen = qctl_r[ACSIC_QEN_BIT];
      // in wake only the mode and service registers take writes
      wr_ok = reg_wr && (!wake || reg_addr == ACSIC_POWER_MODE_OFF
              || reg_addr == ACSIC_ISTAT_OFF || reg_addr == ACSIC_QUEUE_ISTAT_OFF);
      soft_rst = reg_wr && wake && reg_addr == ACSIC_POWER_MODE_OFF
                 && reg_wdata[ACSIC_SWRST_BIT];
      tick = wake && (cnt_r >= rate_period(work_r) - 32'h1);
      qfull_lvl = qen && ({24'h0, queue_count} >= 32'(QUEUE_DEPTH));
      qlvl_lvl = qen && (queue_count >= qthr_r);

      // event gating by feature and enable bits
      ev_set = 8'h00;
      ev_set[ACSIC_TILT_BIT] = motion_event.tilt && feat_r[ACSIC_FEAT_TF_BIT]
                               && int_en_r[ACSIC_TILT_BIT];
      ev_set[ACSIC_FLIP_BIT] = motion_event.flip && feat_r[ACSIC_FEAT_TF_BIT]
                               && int_en_r[ACSIC_FLIP_BIT];
      ev_set[ACSIC_MOVE_BIT] = feat_r[ACSIC_FEAT_MOVE_BIT] && int_en_r[ACSIC_MOVE_BIT]
                               && (motion_event.move || motion_event.stap);
      ev_set[ACSIC_SHAKE_BIT] = motion_event.shake && feat_r[ACSIC_FEAT_SHAKE_BIT]
                                && feat_r[ACSIC_FEAT_MOVE_BIT] && int_en_r[ACSIC_SHAKE_BIT];
      ev_set[ACSIC_DTAP_BIT] = motion_event.dtap && feat_r[ACSIC_FEAT_MOVE_BIT]
                               && int_en_r[ACSIC_DTAP_BIT];
      ev_set[ACSIC_ACQ_BIT] = tick;
      if (!wake) begin
         ev_set = 8'h00;
      end

      // clearing: global on the main address, on the alias only in standby; per bit only on the main address
      clr = 8'h00;
      qclr = 3'h0;
      if (wr_ok && !perbit && (reg_addr == ACSIC_ISTAT_OFF
          || reg_addr == ACSIC_ISTAT_ALIAS_OFF)) begin
         clr = 8'hFF;
         qclr = 3'h7;
      end else if (wr_ok && perbit && reg_addr == ACSIC_ISTAT_OFF) begin
         clr = reg_wdata;
         qclr = {3{reg_wdata[ACSIC_QUEUE_SUM_BIT]}};
      end
      if (reg_rd && (reg_addr == ACSIC_ISTAT_OFF || reg_addr == ACSIC_ISTAT_ALIAS_OFF)) begin
         clr[ACSIC_ACQ_BIT] = 1'b1;
      end
      clr[ACSIC_QUEUE_SUM_BIT] = 1'b0;
   end

   always_comb begin
      istat_view = istat_r;
      istat_view[ACSIC_QUEUE_SUM_BIT] = |qstat_r;
      rd_val = 8'h00;
      if (reg_addr == ACSIC_MOTION_FLAGS_OFF || reg_addr == ACSIC_MOTION_ALT_OFF) begin
         rd_val = {4'h0, motion_live & {feat_r[ACSIC_FEAT_SHAKE_BIT] && feat_r[ACSIC_FEAT_MOVE_BIT],
                   feat_r[ACSIC_FEAT_MOVE_BIT], {2{feat_r[ACSIC_FEAT_TF_BIT]}}}};
      end else if (reg_addr == ACSIC_ISTAT_OFF || reg_addr == ACSIC_ISTAT_ALIAS_OFF) begin
         rd_val = istat_view;
      end else if (reg_addr == ACSIC_DEV_STATUS_OFF) begin
         rd_val = {7'h00, wake};
      end else if (reg_addr == ACSIC_INT_EN_OFF) begin
         rd_val = int_en_r;
      end else if (reg_addr == ACSIC_POWER_MODE_OFF) begin
         rd_val = {7'h00, wake};
      end else if (reg_addr == ACSIC_WORK_MODE_OFF) begin
         rd_val = work_r;
      end else if (reg_addr == ACSIC_FEATURE_OFF) begin
         rd_val = feat_r;
      end else if (reg_addr == ACSIC_QUEUE_FLAGS_OFF) begin
         rd_val = {5'h00, qlvl_lvl, qfull_lvl, 1'b0};
      end else if (reg_addr == ACSIC_X_LO_OFF) begin
         rd_val = axes_r.x[7:0];
      end else if (reg_addr == ACSIC_X_LO_OFF + 8'h1) begin
         rd_val = axes_r.x[15:8];
      end else if (reg_addr == ACSIC_X_LO_OFF + 8'h2) begin
         rd_val = axes_r.y[7:0];
      end else if (reg_addr == ACSIC_X_LO_OFF + 8'h3) begin
         rd_val = axes_r.y[15:8];
      end else if (reg_addr == ACSIC_X_LO_OFF + 8'h4) begin
         rd_val = axes_r.z[7:0];
      end else if (reg_addr == ACSIC_X_LO_OFF + 8'h5) begin
         rd_val = axes_r.z[15:8];
      end else if (reg_addr == ACSIC_RANGE_OFF) begin
         rd_val = {5'h00, range_r};
      end else if (reg_addr == ACSIC_QUEUE_CTL_OFF) begin
         rd_val = qctl_r;
      end else if (reg_addr == ACSIC_QUEUE_THR_OFF) begin
         rd_val = qthr_r;
      end else if (reg_addr == ACSIC_QUEUE_ISTAT_OFF) begin
         rd_val = {5'h00, qstat_r[2:1], 1'b0};
      end else if (reg_addr == ACSIC_ROUTE_OFF) begin
         rd_val = route_r;
      end else if (reg_addr == ACSIC_PIN_CTL_OFF) begin
         rd_val = pinctl_r;
      end
   end

   // request lines and pin shaping
   always_comb begin
      req1 = |(istat_r[ACSIC_SHAKE_BIT:ACSIC_TILT_BIT])
             || (istat_r[ACSIC_ACQ_BIT] && int_en_r[ACSIC_ACQ_BIT]);
      req2 = istat_r[ACSIC_DTAP_BIT] || |qstat_r;
      if (qctl_r[ACSIC_QCOMB_BIT]) begin
         req1 = req1 || req2;
         req2 = 1'b0;
      end
      line_a = route_r[ACSIC_SWAP_BIT] ? req2 : req1;
      line_b = route_r[ACSIC_SWAP_BIT] ? req1 : req2;
      // pin_nxt: {pin2 oe_n, pin2 o, pin1 oe_n, pin1 o}; open drain only ever pulls low
      // polarity 0 makes an asserted line drive the output low
      pin_nxt[0] = line_a ^ ~pinctl_r[ACSIC_P1_POL_BIT];
      pin_nxt[1] = pinctl_r[ACSIC_P1_DRV_BIT] ? 1'b0 : pin_nxt[0];
      pin_nxt[2] = line_b ^ ~pinctl_r[ACSIC_P2_POL_BIT];
      pin_nxt[3] = pinctl_r[ACSIC_P2_DRV_BIT] ? 1'b0 : pin_nxt[2];
   end

   always_comb begin
      state_nxt = state_r;
      int_en_nxt = int_en_r;
      work_nxt = work_r;
      feat_nxt = feat_r;
      qctl_nxt = qctl_r;
      qthr_nxt = qthr_r;
      route_nxt = route_r;
      pinctl_nxt = pinctl_r;
      range_nxt = range_r;
      // set wins over clear
      istat_nxt = (istat_r & ~clr) | ev_set;
      istat_nxt[ACSIC_QUEUE_SUM_BIT] = 1'b0;
      qstat_nxt = qstat_r & ~qclr;
      qstat_nxt[ACSIC_QFULL_BIT] = qstat_nxt[ACSIC_QFULL_BIT]
         || (qfull_lvl && !qfull_d_r && qctl_r[ACSIC_QFULL_BIT]);
      qstat_nxt[ACSIC_QLEVEL_BIT] = qstat_nxt[ACSIC_QLEVEL_BIT]
         || (qlvl_lvl && !qlvl_d_r && qctl_r[ACSIC_QLEVEL_BIT]);
      qstat_nxt[0] = 1'b0;
      qfull_d_nxt = qfull_lvl;
      qlvl_d_nxt = qlvl_lvl;
      cnt_nxt = (wake && !tick) ? cnt_r + 32'h1 : 32'h0;
      tick_nxt = tick;
      stop_nxt = bus_stop || (stop_r && !tick);
      axes_nxt = axes_r;
      if (tick && stop_r) begin
         axes_nxt.x = encode(raw_x, range_r);
         axes_nxt.y = encode(raw_y, range_r);
         axes_nxt.z = encode(raw_z, range_r);
      end
      rdata_nxt = reg_rd ? rd_val : rdata_r;
      if (wr_ok) begin
         if (reg_addr == ACSIC_POWER_MODE_OFF) begin
            if (reg_wdata[1:0] == ACSIC_PM_STANDBY) begin
               state_nxt = ACSIC_STBY;
            end else if (reg_wdata[1:0] == ACSIC_PM_WAKE) begin
               state_nxt = ACSIC_WAKE;
            end
         end else if (reg_addr == ACSIC_INT_EN_OFF) begin
            int_en_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_WORK_MODE_OFF) begin
            work_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_FEATURE_OFF) begin
            feat_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_RANGE_OFF) begin
            range_nxt = (reg_wdata[2:0] > 3'h4) ? range_r : reg_wdata[2:0];
         end else if (reg_addr == ACSIC_QUEUE_CTL_OFF) begin
            qctl_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_QUEUE_THR_OFF) begin
            qthr_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_ROUTE_OFF) begin
            route_nxt = reg_wdata;
         end else if (reg_addr == ACSIC_PIN_CTL_OFF) begin
            pinctl_nxt = reg_wdata;
         end
      end
      if (soft_rst) begin
         state_nxt = ACSIC_STBY;
         int_en_nxt = 8'h00;
         work_nxt = ACSIC_WORK_RST;
         feat_nxt = 8'h00;
         qctl_nxt = 8'h00;
         qthr_nxt = ACSIC_QTHR_RST;
         route_nxt = 8'h00;
         pinctl_nxt = ACSIC_PIN_CTL_RST;
         range_nxt = ACSIC_RANGE_RST;
         istat_nxt = 8'h00;
         qstat_nxt = 3'h0;
         cnt_nxt = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ACSIC_STBY;
         int_en_r <= 8'h00;
         work_r <= ACSIC_WORK_RST;
         feat_r <= 8'h00;
         qctl_r <= 8'h00;
         qthr_r <= ACSIC_QTHR_RST;
         route_r <= 8'h00;
         pinctl_r <= ACSIC_PIN_CTL_RST;
         range_r <= ACSIC_RANGE_RST;
         istat_r <= 8'h00;
         qstat_r <= 3'h0;
         qfull_d_r <= 1'b0;
         qlvl_d_r <= 1'b0;
         cnt_r <= 32'h0;
         stop_r <= 1'b1;
         tick_r <= 1'b0;
         axes_r <= '0;
         rdata_r <= 8'h00;
         pin_r <= 4'hA;
      end else begin
         state_r <= state_nxt;
         int_en_r <= int_en_nxt;
         work_r <= work_nxt;
         feat_r <= feat_nxt;
         qctl_r <= qctl_nxt;
         qthr_r <= qthr_nxt;
         route_r <= route_nxt;
         pinctl_r <= pinctl_nxt;
         range_r <= range_nxt;
         istat_r <= istat_nxt;
         qstat_r <= qstat_nxt;
         qfull_d_r <= qfull_d_nxt;
         qlvl_d_r <= qlvl_d_nxt;
         cnt_r <= cnt_nxt;
         stop_r <= stop_nxt;
         tick_r <= tick_nxt;
         axes_r <= axes_nxt;
         rdata_r <= rdata_nxt;
         pin_r <= pin_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign axis_result = axes_r;
   assign sample_tick = tick_r;
   assign engine_enable = (state_r == ACSIC_WAKE);
   assign range_code = range_r;
   assign work_mode_code = work_r;
   assign queue_enable = qctl_r[ACSIC_QEN_BIT];
   assign first_irq_pin_o = pin_r[0];
   assign first_irq_pin_oe_n = pin_r[1];
   assign second_irq_pin_o = pin_r[2];
   assign second_irq_pin_oe_n = pin_r[3];
endmodule : acsic_core
`default_nettype wire

// >>> bench/acsic_core_chk.sv
// port checker for the accelerometer state and interrupt block
// assumes a bind from tb_top and the single clk domain of the block
`default_nettype none
module acsic_core_chk
   import acsic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire acsic_axes_s axis_result,
   input wire logic sample_tick,
   input wire logic engine_enable,
   input wire logic [2:0] range_code,
   input wire logic [7:0] work_mode_code
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_wake_entry: assert property (
      reg_wr && reg_addr == 8'h07 && reg_wdata[6:0] == 7'h01 |=> engine_enable)
      else $error("wake command not taken at the next edge");
   a_standby_cmd: assert property (
      reg_wr && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h0 |=> !engine_enable)
      else $error("standby command not taken");
   // software reset lands at the same edge as a mode write; the look back also accepts a write two edges earlier
   a_state_cause: assert property (
      $changed(engine_enable) |-> $past(reg_wr) && $past(reg_addr) == 8'h07
      || $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h07)
      else $error("state changed without a mode write");
   a_no_standby_tick: assert property (
      sample_tick |-> $past(engine_enable) || $past(engine_enable, 2))
      else $error("sample tick outside wake");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_axes_on_tick: assert property (
      $changed(axis_result) |-> sample_tick || !engine_enable)
      else $error("axis result changed without a sample");
   a_range_legal: assert property (
      range_code <= 3'h4)
      else $error("range code out of the five ranges");
   a_wake_refuse: assert property (
      engine_enable && reg_wr && reg_addr == 8'h08 |=> $stable(work_mode_code))
      else $error("working mode written in wake");
   a_standby_take: assert property (
      !engine_enable && reg_wr && reg_addr == 8'h08 |=> work_mode_code == $past(reg_wdata))
      else $error("working mode write lost in standby");
endmodule : acsic_core_chk
`default_nettype wire

// >>> bench/acsic_host_model.sv
// host side of the block: pull-ups on both request pins and a stop after every read
// assumes pin enables are active low as the block drives them
`default_nettype none
module acsic_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic pin1_o,
   input wire logic pin1_oe_n,
   input wire logic pin2_o,
   input wire logic pin2_oe_n,
   output logic bus_stop,
   output wire logic pin1_lvl,
   output wire logic pin2_lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   // every read transaction is closed so the next sample may land
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_stop <= 1'b0;
      end else begin
         bus_stop <= reg_rd;
      end
   end
   assign pin1_lvl = pin1_oe_n ? 1'b1 : pin1_o;
   assign pin2_lvl = pin2_oe_n ? 1'b1 : pin2_o;
endmodule : acsic_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for acsic_core through its register strobes
// assumes acsic_pkg, the checker and the host model are compiled first
`default_nettype none
module tb_top
   import acsic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, reg_wr, reg_rd, bus_stop, sample_tick, engine_enable;
   logic p1_o, p1_oe_n, p2_o, p2_oe_n, pin1_lvl, pin2_lvl, queue_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, queue_count, d;
   logic signed [19:0] raw_x, raw_y, raw_z;
   logic [3:0] motion_live;
   acsic_events_s motion_event;
   acsic_axes_s axis_result;
   int mismatches, n_tests, cycles, n;
   // short sample period: 100 Hz gives 200 clocks
   acsic_core #(.CLK_HZ(20000)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bus_stop(bus_stop), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
      .motion_event(motion_event), .motion_live(motion_live), .queue_count(queue_count),
      .axis_result(axis_result), .sample_tick(sample_tick), .engine_enable(engine_enable),
      .range_code(), .work_mode_code(), .queue_enable(queue_enable), .first_irq_pin_o(p1_o),
      .first_irq_pin_oe_n(p1_oe_n), .second_irq_pin_o(p2_o), .second_irq_pin_oe_n(p2_oe_n));
   acsic_host_model host (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .pin1_o(p1_o),
      .pin1_oe_n(p1_oe_n), .pin2_o(p2_o), .pin2_oe_n(p2_oe_n), .bus_stop(bus_stop),
      .pin1_lvl(pin1_lvl), .pin2_lvl(pin2_lvl));
   always #50 clk = ~clk;
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rc
   task automatic pulse(input logic [5:0] e);
      motion_event <= e;
      @(posedge clk);
      motion_event <= 6'h00;
      repeat (3) @(posedge clk);
   endtask : pulse
   // bounded wait; the count doubles as the measured period
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (sample_tick !== 1'b1 && c < 400);
   endtask : wait_tick
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, queue_count, motion_live} = '0;
      motion_event = '0;
      raw_x = 20'sd16384;
      raw_y = 20'sh7FFFF;
      raw_z = 20'sh80000;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(engine_enable, 1'b0);
      chk({pin1_lvl, pin2_lvl}, 2'b11);
      rc(8'h08, 8'h13);
      rc(8'h2E, 8'h10);
      rc(8'h33, 8'h00);
      rc(8'hFF, 8'h00);
      wr(8'h20, 8'h03);
      wr(8'h20, 8'h05);
      rc(8'h20, 8'h03);
      wr(8'h08, 8'h6C);
      wr(8'h06, 8'h01);
      wr(8'h09, 8'h01);
      wr(8'h2D, 8'h24);
      chk(queue_enable, 1'b1);
      wr(8'h07, 8'h01);
      rc(8'h05, 8'h01);
      wr(8'h08, 8'h3B);
      rc(8'h08, 8'h6C);
      pulse(6'h20);
      chk(pin1_lvl, 1'b0);
      pulse(6'h02);
      rd(8'h14, d);
      chk(d[4:0], 5'h01);
      wr(8'h14, 8'h00);
      @(posedge clk);
      chk(pin1_lvl, 1'b1);
      wait_tick(n);
      chk(axis_result, {16'd2730, 16'h7FFF, 16'h8000});
      wait_tick(n);
      chk(n, 200);
      rd(8'h14, d);
      chk(d[7], 1'b1);
      rd(8'h14, d);
      chk(d[7], 1'b0);
      queue_count <= 8'd20;
      repeat (3) @(posedge clk);
      chk(pin2_lvl, 1'b0);
      rc(8'h2F, 8'h04);
      wr(8'h2F, 8'h00);
      rc(8'h2F, 8'h04);
      wr(8'h14, 8'h00);
      rc(8'h2F, 8'h00);
      chk(pin2_lvl, 1'b1);
      wr(8'h07, 8'h00);
      chk(engine_enable, 1'b0);
      wr(8'h31, 8'h50);
      wr(8'h33, 8'h0C);
      wr(8'h07, 8'h01);
      pulse(6'h20);
      chk({p1_oe_n, p1_o, pin2_lvl}, 3'b000);
      // per-bit clearing: a zero leaves a flag, a one clears only its own bit
      wr(8'h14, 8'h02);
      rd(8'h14, d);
      chk(d[5:0], 6'h01);
      wr(8'h14, 8'h01);
      rd(8'h14, d);
      chk({d[0], pin2_lvl}, 2'b01);
      // merged requests follow line one, which the swap puts on the second pin
      wr(8'h07, 8'h00);
      wr(8'h2D, 8'h2C);
      queue_count <= 8'h00;
      @(posedge clk);
      queue_count <= 8'h14;
      repeat (3) @(posedge clk);
      chk({p1_o, pin2_lvl}, 2'b00);
      // software reset is taken only in wake and restores every control register; the axis data keeps its value
      wr(8'h07, 8'h01);
      wr(8'h07, 8'h41);
      @(posedge clk);
      chk({engine_enable, queue_enable, pin1_lvl, pin2_lvl}, 4'b0011);
      rc(8'h33, 8'h00);
      end_of_test();
   end
endmodule : tb_top
bind acsic_core acsic_core_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .axis_result(axis_result), .sample_tick(sample_tick), .engine_enable(engine_enable),
   .range_code(range_code), .work_mode_code(work_mode_code));
`default_nettype wire
